/* File: common/keyswitch_consts.svh */
// offsets, field positions, reset values and timing figures of the key/switch bank
`ifndef KEYSWITCH_CONSTS_SVH
`define KEYSWITCH_CONSTS_SVH

// register offsets
`define OFS_KEY_DETECT 8'h05
`define OFS_THRESH_DEBOUNCE 8'h06
`define OFS_SWITCH_CTRL 8'h07

// key_detect_settings fields
`define KD_ENABLE_BIT 2
`define KD_RAW_BIT 1
`define KD_TRIG_BIT 0

// key_threshold_debounce fields
`define TD_BIAS_MSB 5
`define TD_BIAS_LSB 3
`define TD_REL_BIT 2
`define TD_PRESS_MSB 1
`define TD_PRESS_LSB 0

// switch_override_control field width, ground/depletion/route bits 5..0
`define SW_MSB 5

// reset values
`define TD_BIAS_RST 3'h1
`define TD_REL_RST 1'h1
`define TD_PRESS_RST 2'h2
`define SW_RST 6'h00

// permitted tip/ring route matrix positions while key detection runs
`define ROUTE_POS_A 4'h5
`define ROUTE_POS_B 4'ha

// timing
`define CLK_KHZ 200000
`define PRESS_T0_MS 2
`define PRESS_T1_MS 40
`define PRESS_T2_MS 80
`define PRESS_T3_MS 120
`define REL_T0_MS 2
`define REL_T1_MS 2
`define SETTLE_CNT_W 25

`endif

/* File: common/keyswitch_pkg.sv */
// types shared by the key/switch register bank
`default_nettype none
package keyswitch_pkg;

	typedef enum logic [1:0] {
		ST_RELEASED = 2'b00,
		ST_PRESS_WAIT = 2'b01,
		ST_HELD = 2'b10,
		ST_REL_WAIT = 2'b11
	} settle_state_t;

endpackage : keyswitch_pkg
`default_nettype wire

/* File: design/key_settle_timer.sv */
// press and release settle timer for the key comparator level
`timescale 1ns/1ps
`default_nettype none
`include "keyswitch_consts.svh"
module key_settle_timer
	import keyswitch_pkg::*;
(
	// clock and reset
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic clk_en_in,
	// control
	input wire logic run_in,
	input wire logic level_in,
	input wire logic [`SETTLE_CNT_W-1:0] press_limit_in,
	input wire logic [`SETTLE_CNT_W-1:0] release_limit_in,
	// settled events
	output logic press_out,
	output logic release_out
);

	settle_state_t state_q, state_d;
	logic [`SETTLE_CNT_W-1:0] cnt_q, cnt_d;
	logic press_q, press_d;
	logic release_q, release_d;

	always_comb begin
		state_d = state_q;
		cnt_d = cnt_q + 1'b1;
		press_d = 1'b0;
		release_d = 1'b0;
		unique case (state_q)
			ST_RELEASED: begin
				cnt_d = '0;
				if (level_in) begin
					state_d = ST_PRESS_WAIT;
				end
			end
			ST_PRESS_WAIT: begin
				if (!level_in) begin
					state_d = ST_RELEASED;
					cnt_d = '0;
				end else if (cnt_q >= press_limit_in - 1'b1) begin
					state_d = ST_HELD;
					press_d = 1'b1;
				end
			end
			ST_HELD: begin
				cnt_d = '0;
				if (!level_in) begin
					state_d = ST_REL_WAIT;
				end
			end
			ST_REL_WAIT: begin
				if (level_in) begin
					state_d = ST_HELD;
					cnt_d = '0;
				end else if (cnt_q >= release_limit_in - 1'b1) begin
					state_d = ST_RELEASED;
					release_d = 1'b1;
				end
			end
		endcase
		// stopping detection drops a half-settled key without an event
		if (!run_in) begin
			state_d = ST_RELEASED;
			cnt_d = '0;
			press_d = 1'b0;
			release_d = 1'b0;
		end
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			state_q <= ST_RELEASED;
			cnt_q <= '0;
			press_q <= 1'b0;
			release_q <= 1'b0;
		end else if (clk_en_in) begin
			state_q <= state_d;
			cnt_q <= cnt_d;
			press_q <= press_d;
			release_q <= release_d;
		end
	end

	assign press_out = press_q;
	assign release_out = release_q;

endmodule : key_settle_timer
`default_nettype wire

/* File: design/audio_jack_keypress_switch_regs.sv */
// key detection, threshold/debounce and switch override register bank
`timescale 1ns/1ps
`default_nettype none
`include "keyswitch_consts.svh"
// Notes on behaviour
// - key detect enable bit, resets 0, upper bits zero
// - accessory removal clears key detect enable
// - under override, detect only in permitted route
// - raw mode drops when key detect off
// - raw mode entry keeps key event flags
// - raw mode reports press/release and conversion results
// - manual trigger needs enable and raw mode
// - trigger bit clears when its conversion ends
// - trigger accepted despite pending done flag
// - bias threshold field, resets to one
// - release settle select, both codes two ms
// - press settle select two to 120 ms
// - switch bits act only under override
// - ground switch bits, reserved bits zero
// - depletion and route switch bits, reset off
// - override makes switches follow control register
// - conversion result in bits seven to one
module audio_jack_keypress_switch_regs
	import keyswitch_pkg::*;
#(
	parameter int unsigned PRESS_CYC0 = `PRESS_T0_MS * `CLK_KHZ,
	parameter int unsigned PRESS_CYC1 = `PRESS_T1_MS * `CLK_KHZ,
	parameter int unsigned PRESS_CYC2 = `PRESS_T2_MS * `CLK_KHZ,
	parameter int unsigned PRESS_CYC3 = `PRESS_T3_MS * `CLK_KHZ,
	parameter int unsigned REL_CYC0 = `REL_T0_MS * `CLK_KHZ,
	parameter int unsigned REL_CYC1 = `REL_T1_MS * `CLK_KHZ
) (
	// clock, reset, enable
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic clk_en_in,
	// register port behind the serial slave
	input wire logic [7:0] reg_addr_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	input wire logic [7:0] reg_wdata_in,
	output logic [7:0] reg_rdata_out,
	// device state from the rest of the chip
	input wire logic removal_event_in,
	input wire logic switch_override_in,
	input wire logic [3:0] tip_ring_route_matrix_in,
	input wire logic [5:0] auto_switch_in,
	input wire logic key_level_in,
	// converter
	input wire logic conv_done_in,
	input wire logic [6:0] conv_data_in,
	output logic conv_start_out,
	output logic [7:0] conv_result_out,
	// key detection
	output logic key_detect_run_out,
	output logic [2:0] microphone_bias_level_out,
	output logic key_press_settled_out,
	output logic key_release_settled_out,
	output logic key1_press_evt_out,
	output logic key2_press_release_evt_out,
	output logic conv_done_flag_out,
	// switches
	output logic [5:0] switch_state_out
);

	logic key_en_q, key_en_d;
	logic raw_q, raw_d;
	logic trig_q, trig_d;
	logic [2:0] bias_q, bias_d;
	logic rel_sel_q, rel_sel_d;
	logic [1:0] press_sel_q, press_sel_d;
	logic [5:0] sw_q, sw_d;
	logic [5:0] sw_state_q, sw_state_d;
	logic [7:0] rdata_q, rdata_d;
	logic busy_q, busy_d;
	logic manual_q, manual_d;
	logic [6:0] result_q, result_d;
	logic start_q, start_d;
	logic done_flag_q, done_flag_d;
	logic key1_q, key1_d;
	logic key2_q, key2_d;

	logic wr_kd, wr_td, wr_sw;
	logic route_ok, run;
	logic settled_press, settled_release;
	logic finish, manual_finish;
	logic [`SETTLE_CNT_W-1:0] press_limit, release_limit;

	assign wr_kd = reg_wr_in && (reg_addr_in == `OFS_KEY_DETECT);
	assign wr_td = reg_wr_in && (reg_addr_in == `OFS_THRESH_DEBOUNCE);
	assign wr_sw = reg_wr_in && (reg_addr_in == `OFS_SWITCH_CTRL);

	// the route check only matters while the host owns the switches
	assign route_ok = (tip_ring_route_matrix_in == `ROUTE_POS_A) ||
		(tip_ring_route_matrix_in == `ROUTE_POS_B);
	assign run = key_en_q && (!switch_override_in || route_ok);

	assign finish = conv_done_in && busy_q;
	assign manual_finish = finish && manual_q;

	always_comb begin
		unique case (press_sel_q)
			2'h0: press_limit = `SETTLE_CNT_W'(PRESS_CYC0);
			2'h1: press_limit = `SETTLE_CNT_W'(PRESS_CYC1);
			2'h2: press_limit = `SETTLE_CNT_W'(PRESS_CYC2);
			2'h3: press_limit = `SETTLE_CNT_W'(PRESS_CYC3);
		endcase
		release_limit = rel_sel_q ? `SETTLE_CNT_W'(REL_CYC1) : `SETTLE_CNT_W'(REL_CYC0);
	end

	key_settle_timer u_settle (
		.clk_in(clk_in),
		.rst_n_in(rst_n_in),
		.clk_en_in(clk_en_in),
		.run_in(run),
		.level_in(key_level_in),
		.press_limit_in(press_limit),
		.release_limit_in(release_limit),
		.press_out(settled_press),
		.release_out(settled_release)
	);

	always_comb begin
		key_en_d = key_en_q;
		if (wr_kd) begin
			key_en_d = reg_wdata_in[`KD_ENABLE_BIT];
		end
		// removal beats a same-cycle write of one
		if (removal_event_in) begin
			key_en_d = 1'b0;
		end
		// raw mode entry drives no clear toward the key event flags
		raw_d = wr_kd ? reg_wdata_in[`KD_RAW_BIT] : raw_q;
		raw_d = raw_d && key_en_d;
		trig_d = trig_q;
		if (manual_finish) begin
			trig_d = 1'b0;
		end
		// no dependency on the done flag, so a new request is never blocked
		if (wr_kd && reg_wdata_in[`KD_TRIG_BIT] && key_en_d && raw_d) begin
			trig_d = 1'b1;
		end
		trig_d = trig_d && raw_d;
	end

	always_comb begin
		bias_d = bias_q;
		rel_sel_d = rel_sel_q;
		press_sel_d = press_sel_q;
		sw_d = sw_q;
		if (wr_td) begin
			bias_d = reg_wdata_in[`TD_BIAS_MSB:`TD_BIAS_LSB];
			rel_sel_d = reg_wdata_in[`TD_REL_BIT];
			press_sel_d = reg_wdata_in[`TD_PRESS_MSB:`TD_PRESS_LSB];
		end
		if (wr_sw) begin
			sw_d = reg_wdata_in[`SW_MSB:0];
		end
		// registered so the pins never glitch on a mid-cycle override change
		sw_state_d = switch_override_in ? sw_q : auto_switch_in;
	end

	always_comb begin
		busy_d = busy_q;
		manual_d = manual_q;
		result_d = result_q;
		start_d = 1'b0;
		done_flag_d = 1'b0;
		if (finish) begin
			busy_d = 1'b0;
			manual_d = 1'b0;
			if (raw_q || manual_q) begin
				result_d = conv_data_in;
			end
			done_flag_d = manual_q;
		end else if (!busy_q && trig_q) begin
			// manual request waits behind any auto conversion in flight
			busy_d = 1'b1;
			manual_d = 1'b1;
			start_d = 1'b1;
		end else if (!busy_q && settled_press) begin
			busy_d = 1'b1;
			start_d = 1'b1;
		end
		key1_d = raw_q && settled_press;
		key2_d = raw_q && settled_release;
	end

	always_comb begin
		rdata_d = rdata_q;
		if (reg_rd_in) begin
			unique case (reg_addr_in)
				`OFS_KEY_DETECT: rdata_d = {5'h00, key_en_q, raw_q, trig_q};
				`OFS_THRESH_DEBOUNCE: rdata_d = {2'h0, bias_q, rel_sel_q, press_sel_q};
				`OFS_SWITCH_CTRL: rdata_d = {2'h0, sw_q};
				default: rdata_d = 8'h00;
			endcase
		end
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			key_en_q <= 1'b0;
			raw_q <= 1'b0;
			trig_q <= 1'b0;
			bias_q <= `TD_BIAS_RST;
			rel_sel_q <= `TD_REL_RST;
			press_sel_q <= `TD_PRESS_RST;
			sw_q <= `SW_RST;
			sw_state_q <= `SW_RST;
			rdata_q <= 8'h00;
			busy_q <= 1'b0;
			manual_q <= 1'b0;
			result_q <= 7'h00;
			start_q <= 1'b0;
			done_flag_q <= 1'b0;
			key1_q <= 1'b0;
			key2_q <= 1'b0;
		end else if (clk_en_in) begin
			key_en_q <= key_en_d;
			raw_q <= raw_d;
			trig_q <= trig_d;
			bias_q <= bias_d;
			rel_sel_q <= rel_sel_d;
			press_sel_q <= press_sel_d;
			sw_q <= sw_d;
			sw_state_q <= sw_state_d;
			rdata_q <= rdata_d;
			busy_q <= busy_d;
			manual_q <= manual_d;
			result_q <= result_d;
			start_q <= start_d;
			done_flag_q <= done_flag_d;
			key1_q <= key1_d;
			key2_q <= key2_d;
		end
	end

	assign reg_rdata_out = rdata_q;
	assign conv_start_out = start_q;
	assign conv_result_out = {result_q, 1'b0};
	assign key_detect_run_out = run;
	assign microphone_bias_level_out = bias_q;
	assign key_press_settled_out = settled_press;
	assign key_release_settled_out = settled_release;
	assign key1_press_evt_out = key1_q;
	assign key2_press_release_evt_out = key2_q;
	assign conv_done_flag_out = done_flag_q;
	assign switch_state_out = sw_state_q;

	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!rst_n_in);

	removal_clears_a: assert property (clk_en_in && removal_event_in |=> !key_en_q)
		else $error("key detect enable survived a removal");

	raw_needs_en_a: assert property (!key_en_q |-> !raw_q)
		else $error("raw mode set while key detect is off");

	trig_gated_a: assert property (
		clk_en_in && wr_kd && !trig_q &&
		!(reg_wdata_in[`KD_ENABLE_BIT] && reg_wdata_in[`KD_RAW_BIT])
		|=> !trig_q)
		else $error("trigger taken without enable and raw mode");

	trig_done_a: assert property (
		clk_en_in && manual_finish && !wr_kd |=> !trig_q && done_flag_q)
		else $error("trigger not cleared or done flag missing");

	trig_starts_a: assert property (
		clk_en_in && trig_q && !busy_q && raw_q && !removal_event_in && !wr_kd
		|=> start_q && busy_q)
		else $error("pending trigger did not start a conversion");

	override_follow_a: assert property (
		clk_en_in && switch_override_in |=> switch_state_out == $past(sw_q))
		else $error("switches do not follow the control register");

	auto_keep_a: assert property (
		clk_en_in && !switch_override_in |=> switch_state_out == $past(auto_switch_in))
		else $error("control register leaked onto switches");

	reserved_zero_a: assert property (
		clk_en_in && reg_rd_in && reg_addr_in == `OFS_KEY_DETECT
		|=> reg_rdata_out[7:3] == 5'h00 && reg_rdata_out[2] == $past(key_en_q))
		else $error("key detect readback wrong");

	route_gate_a: assert property (
		key_en_q && switch_override_in && !route_ok |-> !key_detect_run_out)
		else $error("key detection ran in a forbidden route");

	raw_event_a: assert property (
		clk_en_in && raw_q && settled_release |=> key2_press_release_evt_out)
		else $error("raw mode release not reported");

	result_load_a: assert property (
		clk_en_in && finish && raw_q
		|=> conv_result_out == {$past(conv_data_in), 1'b0})
		else $error("conversion result not loaded");

	manual_conv_c: cover property (trig_q ##[1:20] conv_done_flag_out);
	raw_press_c: cover property (key1_press_evt_out);
	override_on_c: cover property (!switch_override_in ##1 switch_override_in);
	removal_c: cover property (key_en_q && raw_q ##1 removal_event_in);

endmodule : audio_jack_keypress_switch_regs
`default_nettype wire

/* File: test/conv_model.sv */
// converter model answering start pulses after a chosen delay
`timescale 1ns/1ps
`default_nettype none
module conv_model (
	// clock and reset
	input wire logic clk_in,
	input wire logic rst_n_in,
	// request and setup
	input wire logic start_in,
	input wire logic [3:0] delay_in,
	input wire logic [6:0] data_in,
	// answer
	output logic done_out,
	output logic [6:0] data_out
);
	logic [3:0] cnt_q;
	logic busy_q;
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			{busy_q, cnt_q, done_out, data_out} <= '0;
		end else begin
			done_out <= 1'b0;
			// data toggles outside done so a stale value never matches
			data_out <= ~data_out;
			if (start_in) begin
				busy_q <= 1'b1;
				cnt_q <= delay_in;
			end else if (busy_q) begin
				if (cnt_q == 4'h0) begin
					busy_q <= 1'b0;
					done_out <= 1'b1;
					data_out <= data_in;
				end else begin
					cnt_q <= cnt_q - 4'h1;
				end
			end
		end
	end
endmodule : conv_model
`default_nettype wire

/* File: test/audio_jack_keypress_switch_regs_tb.sv */
// self-checking bench of the key/switch register bank
`timescale 1ns/1ps
`default_nettype none
module audio_jack_keypress_switch_regs_tb;
	logic clk_in, rst_n_in, clk_en_in, reg_wr_in, reg_rd_in, removal_event_in;
	logic switch_override_in, key_level_in, conv_done_in, conv_start_out;
	logic [7:0] reg_addr_in, reg_wdata_in, reg_rdata_out, conv_result_out, v;
	logic [3:0] route, delay;
	logic [5:0] auto_sw, sw;
	logic [6:0] cdata, conv_data_in;
	logic [2:0] bias;
	logic run, pset, rset, k1, k2, flag;
	logic rd_q = 1'b0;
	logic [7:0] exp_q[$], res_q[$];
	int n_fail, checked, i, n, k1_n, k2_n;
	int plim[4] = '{4, 8, 12, 16};
	int rlim[2] = '{5, 6};
	audio_jack_keypress_switch_regs #(.PRESS_CYC0(4), .PRESS_CYC1(8), .PRESS_CYC2(12),
		.PRESS_CYC3(16), .REL_CYC0(5), .REL_CYC1(6)) i_dut (.clk_in(clk_in),
		.rst_n_in(rst_n_in), .clk_en_in(clk_en_in), .reg_addr_in(reg_addr_in),
		.reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_wdata_in(reg_wdata_in),
		.reg_rdata_out(reg_rdata_out), .removal_event_in(removal_event_in),
		.switch_override_in(switch_override_in), .tip_ring_route_matrix_in(route),
		.auto_switch_in(auto_sw), .key_level_in(key_level_in), .conv_done_in(conv_done_in),
		.conv_data_in(conv_data_in), .conv_start_out(conv_start_out),
		.conv_result_out(conv_result_out), .key_detect_run_out(run),
		.microphone_bias_level_out(bias), .key_press_settled_out(pset),
		.key_release_settled_out(rset), .key1_press_evt_out(k1),
		.key2_press_release_evt_out(k2), .conv_done_flag_out(flag), .switch_state_out(sw));
	conv_model i_conv (.clk_in(clk_in), .rst_n_in(rst_n_in), .start_in(conv_start_out),
		.delay_in(delay), .data_in(cdata), .done_out(conv_done_in), .data_out(conv_data_in));
	task check(input logic [7:0] seen, input logic [7:0] exp);
		checked++;
		if (seen !== exp) begin
			n_fail++;
			$display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task results;
		if (n_fail == 0 && checked > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask : results
	task tout(input int cnt);
		if (cnt >= 100) begin
			n_fail++;
			results();
		end
	endtask : tout
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_in);
		reg_addr_in <= a;
		reg_wdata_in <= d;
		reg_wr_in <= 1'b1;
		@(posedge clk_in);
		reg_wr_in <= 1'b0;
	endtask : wr
	task rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge clk_in);
		reg_addr_in <= a;
		reg_rd_in <= 1'b1;
		exp_q.push_back(e);
		@(posedge clk_in);
		reg_rd_in <= 1'b0;
	endtask : rd
	// monitor: read data one cycle after the read edge, results with the done flag
	always @(posedge clk_in) begin
		if (rd_q) check(reg_rdata_out, exp_q.pop_front());
		rd_q <= reg_rd_in && rst_n_in;
		if (flag === 1'b1) check(conv_result_out, res_q.size() ? res_q.pop_front() : 8'hxx);
		if (k1 === 1'b1) k1_n++;
		if (k2 === 1'b1) k2_n++;
	end
	initial begin
		clk_in = 1'b0;
		forever #2.5 clk_in = ~clk_in;
	end
	initial begin
		#400us;
		n_fail++;
		results();
	end
	initial begin
		void'($urandom(32'hcc06));
		{rst_n_in, reg_wr_in, reg_rd_in, removal_event_in, switch_override_in, key_level_in} = '0;
		{reg_addr_in, reg_wdata_in, route, auto_sw, cdata} = '0;
		clk_en_in = 1'b1;
		delay = 4'h1;
		repeat (12) @(posedge clk_in);
		rst_n_in <= 1'b1;
		rd(8'h05, 8'h00);
		rd(8'h06, 8'h0e);
		rd(8'h07, 8'h00);
		rd(8'h20, 8'h00);
		wr(8'h05, 8'hf6);
		rd(8'h05, 8'h06);
		v = 8'($urandom);
		wr(8'h06, v);
		rd(8'h06, v & 8'h3f);
		check({5'h0, bias}, {5'h0, v[5:3]});
		// a write while the enable is low must not land
		clk_en_in <= 1'b0;
		wr(8'h06, ~v);
		clk_en_in <= 1'b1;
		rd(8'h06, v & 8'h3f);
		v = 8'($urandom);
		wr(8'h07, v);
		rd(8'h07, v & 8'h3f);
		for (i = 0; i < 2; i++) begin
			switch_override_in <= i[0];
			auto_sw <= 6'($urandom);
			repeat (3) @(posedge clk_in);
			check({2'b00, sw}, i ? v & 8'h3f : {2'b00, auto_sw});
		end
		for (i = 0; i < 17; i++) begin
			route <= i[3:0];
			if (i == 16) switch_override_in <= 1'b0;
			repeat (2) @(posedge clk_in);
			check({7'h0, run}, {7'h0, i == 5 || i == 10 || i == 16});
		end
		for (i = 0; i < 2; i++) begin
			delay <= 4'(i * 9 + 1);
			cdata <= 7'($urandom);
			@(posedge clk_in);
			res_q.push_back({cdata, 1'b0});
			wr(8'h05, 8'h07);
			for (n = 0; n < 100 && flag !== 1'b1; n++) @(posedge clk_in);
			tout(n);
			rd(8'h05, 8'h06);
		end
		wr(8'h05, 8'h05);
		repeat (20) @(posedge clk_in);
		rd(8'h05, 8'h04);
		wr(8'h05, 8'h02);
		rd(8'h05, 8'h00);
		wr(8'h05, 8'h06);
		removal_event_in <= 1'b1;
		@(posedge clk_in);
		removal_event_in <= 1'b0;
		rd(8'h05, 8'h00);
		wr(8'h05, 8'h06);
		// last pass runs without raw mode, so no events are expected from it
		for (i = 0; i < 5; i++) begin
			if (i == 4) wr(8'h05, 8'h04);
			else wr(8'h06, {5'h1, i[0], i[1:0]});
			key_level_in <= 1'b1;
			for (n = 0; n < 100 && pset !== 1'b1; n++) @(posedge clk_in);
			tout(n);
			if (i < 4) check({7'h0, n >= plim[i] && n <= plim[i] + 3}, 8'h01);
			key_level_in <= 1'b0;
			for (n = 0; n < 100 && rset !== 1'b1; n++) @(posedge clk_in);
			tout(n);
			if (i < 4) check({7'h0, n >= rlim[i % 2] && n <= rlim[i % 2] + 3}, 8'h01);
			repeat (30) @(posedge clk_in);
		end
		check(k1_n[7:0], 8'h04);
		check(k2_n[7:0], 8'h04);
		results();
	end
endmodule : audio_jack_keypress_switch_regs_tb
`default_nettype wire
